// [core/scc_params.svh]
// Constants for the slow-clock and divider controller: offsets, fields, timing.
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define SCC_REG_CLKCTL_IDX 10'h0C6
`define SCC_REG_STATUS_IDX 10'h0C8
`define SCC_REG_PMREQ_IDX 10'h0C9

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define SCC_SLOW_SEL_BIT 7
`define SCC_OSC_BIT 6
`define SCC_TICK_MSB 5
`define SCC_TICK_LSB 3
`define SCC_SYSDIV_MSB 2
`define SCC_SYSDIV_LSB 0
`define SCC_PMREQ_BIT 0
`define SCC_CLKCTL_RESET 8'hC9
`define SCC_DIV_MIN_RC 3'h1

// ********************************************************************
// Calibration targets: 750 and 1500 crystal periods per slow cycle
// ********************************************************************
`define SCC_RATIO_26M 11'h2EE
`define SCC_RATIO_48M 11'h5DC

// ********************************************************************
// Timing
// ********************************************************************
`define SCC_CLK_KHZ 200000
`define SCC_CAL_TIME_MS 2
`define SCC_ABORT_TIME_US 130

`endif

// [core/scc_pkg.sv]
// Types shared by the slow-clock and divider controller.
`default_nettype none
package scc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT_XOSC = 3'h1,
		ST_INIT_CAL = 3'h2,
		ST_CONT_CAL = 3'h3,
		ST_ABORT = 3'h4,
		ST_SWITCH = 3'h5
	} scc_state_e;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [11:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} scc_wb_req_s;

endpackage
`default_nettype wire

// [core/scc_sync.sv]
// Two-flop synchroniser for the oscillator and mode status pins.
`timescale 1ns/10ps
`default_nettype none
module scc_sync (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous reset, active high
	input wire logic [3:0] async_in, // pins from other domains
	output logic [3:0] sync_out // synchronised copies
);

	logic [3:0] meta_q;
	logic [3:0] sync_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule
`default_nettype wire

// [core/scc_divider.sv]
// Power-of-two divider giving a one-cycle strobe per divided period.
`timescale 1ns/10ps
`default_nettype none
module scc_divider (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous reset, active high
	input wire logic ref_en, // reference enable
	input wire logic [2:0] code, // divide by two to this power
	output logic tick // strobe, one cycle
);

	logic [6:0] cnt_q;
	logic tick_q;
	logic [6:0] mask;

	assign mask = 7'((8'h01 << code) - 8'h01);

	// Comparing with >= lets a smaller code take effect without a wrap.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt_q <= 7'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= 1'b0;
			if (ref_en)
			begin
				if (cnt_q >= mask)
				begin
					cnt_q <= 7'h00;
					tick_q <= 1'b1;
				end
				else
				begin
					cnt_q <= cnt_q + 7'h01;
				end
			end
		end
	end

	assign tick = tick_q;

endmodule
`default_nettype wire

// [core/scc_clock_ctrl.sv]
// Slow-clock source select, RC calibration sequencing and clock dividers.
//
// Contract
// RULE1 - Slow crystal and low-power RC oscillator are never enabled together.
// RULE2 - Reset enables the low-power RC oscillator and selects it.
// RULE3 - Slow select 0 picks the 32.768 kHz crystal, 1 the RC.
// RULE4 - Software changes slow select only while fast RC drives the system.
// RULE5 - RC calibration needs RC running and fast crystal stable; starts on it.
// RULE6 - Calibrated RC runs at crystal over 750, or 1500 on 48 MHz.
// RULE7 - Calibration repeats while on crystal in active or lightest mode.
// RULE8 - Each calibration pass lasts about 2 ms.
// RULE9 - After the first pass, switch to RC or deep mode aborts calibration.
// RULE10 - Requests during the first pass wait until that pass finishes.
// RULE11 - After the first pass, abort and act about 130 us after request.
// RULE12 - Software requests once in the first pass, then not within 130 us.
// RULE13 - Tick is reference over two to the field; 000 barred on fast RC.
// RULE14 - System divider likewise; new value applies after a clock change. Code applies it at once unless a switch is running.
// RULE15 - System source changes only once the new oscillator reports stable.
// RULE16 - Software keeps the tick divider no faster than the system divider.
// RULE17 - System select 0 picks the fast crystal and starts fast RC calibration.
// RULE18 - A flag records whether the first pass since selection has finished.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "scc_params.svh"
module scc_clock_ctrl
	import scc_pkg::*;
#(
	parameter logic [19:0] CAL_CYCLES = 20'(`SCC_CAL_TIME_MS * `SCC_CLK_KHZ),
	parameter logic [19:0] ABORT_CYCLES =
		20'(`SCC_ABORT_TIME_US * `SCC_CLK_KHZ / 1000)
)(
	input wire logic clk, // system clock, 200 MHz
	input wire logic reset, // synchronous reset, active high
	input wire scc_wb_req_s wb_req, // Wishbone request group
	output logic wb_ack, // Wishbone acknowledge
	output logic [31:0] wb_rdata, // Wishbone read data
	input wire logic xosc_stable, // fast crystal stable, async
	input wire logic rc_stable, // fast RC stable, async
	input wire logic light_mode, // active or lightest mode, async
	input wire logic variant_48m, // 48 MHz crystal variant, async
	output logic lp_xtal_en, // slow crystal enable
	output logic lp_rc_en, // low-power RC enable
	output logic sys_src_rc, // system runs on fast RC
	output logic fast_rc_cal, // fast RC calibration busy
	output logic lp_cal_busy, // low-power RC calibration busy
	output logic [10:0] lp_cal_ratio, // calibration target ratio
	output logic sys_clk_en, // divided system clock strobe
	output logic timer_tick, // timer tick strobe
	output logic deep_pm_enter // deep power mode entry strobe
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [3:0] pins_s;
	logic xosc_stb_s;
	logic rc_stb_s;
	logic light_s;
	logic var_s;

	scc_sync u_sync (
		.clk(clk),
		.reset(reset),
		.async_in({variant_48m, light_mode, rc_stable, xosc_stable}),
		.sync_out(pins_s)
	);

	assign xosc_stb_s = pins_s[0];
	assign rc_stb_s = pins_s[1];
	assign light_s = pins_s[2];
	assign var_s = pins_s[3];

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************
	scc_state_e st_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic slow_sel_q;
	logic osc_req_q;
	logic [2:0] tick_q;
	logic [2:0] sysdiv_q;
	logic pm_req_q;
	logic sys_src_rc_q;
	logic init_done_q;
	logic pend_pm_q;
	logic lp_rc_en_q;
	logic lp_xtal_en_q;
	logic lp_cal_busy_q;
	logic acc;
	logic wr;
	logic hit_ctl;
	logic hit_sts;
	logic hit_pm;
	logic [7:0] rd_byte;
	localparam logic [7:0] CTL_RST = `SCC_CLKCTL_RESET;

	assign acc = wb_req.cyc & wb_req.stb & ~ack_q;
	assign wr = acc & wb_req.we & wb_req.sel[0];
	assign hit_ctl = wb_req.adr[11:2] == `SCC_REG_CLKCTL_IDX;
	assign hit_sts = wb_req.adr[11:2] == `SCC_REG_STATUS_IDX;
	assign hit_pm = wb_req.adr[11:2] == `SCC_REG_PMREQ_IDX;

	// Bit 6 shows the source in use, which lags a write until the switch.
	always_comb
	begin
		rd_byte = 8'h00;
		if (hit_ctl)
			rd_byte = {slow_sel_q, sys_src_rc_q, tick_q, sysdiv_q};
		else if (hit_sts)
			rd_byte = {2'h0, pend_pm_q, lp_xtal_en_q, lp_rc_en_q,
				st_q == ST_ABORT, lp_cal_busy_q, init_done_q};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= acc;
			if (acc)
				rdata_q <= {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			slow_sel_q <= CTL_RST[`SCC_SLOW_SEL_BIT]; // [RULE2]
			osc_req_q <= CTL_RST[`SCC_OSC_BIT];
			tick_q <= CTL_RST[`SCC_TICK_MSB:`SCC_TICK_LSB];
			sysdiv_q <= CTL_RST[`SCC_SYSDIV_MSB:`SCC_SYSDIV_LSB];
		end
		else if (wr && hit_ctl)
		begin
			// A select write off the fast RC is dropped. [RULE4]
			if (sys_src_rc_q && st_q == ST_IDLE)
				slow_sel_q <= wb_req.dat[`SCC_SLOW_SEL_BIT];
			osc_req_q <= wb_req.dat[`SCC_OSC_BIT];
			tick_q <= wb_req.dat[`SCC_TICK_MSB:`SCC_TICK_LSB];
			sysdiv_q <= wb_req.dat[`SCC_SYSDIV_MSB:`SCC_SYSDIV_LSB];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			pm_req_q <= 1'b0;
		else
			pm_req_q <= wr & hit_pm & wb_req.dat[`SCC_PMREQ_BIT];
	end

	// ****************************************************************
	// Slow source enables, break before make
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lp_rc_en_q <= 1'b1; // [RULE2]
			lp_xtal_en_q <= 1'b0;
		end
		else
		begin
			lp_rc_en_q <= slow_sel_q & ~lp_xtal_en_q; // [RULE1] [RULE3]
			lp_xtal_en_q <= ~slow_sel_q & ~lp_rc_en_q; // [RULE1] [RULE3]
		end
	end

	// ****************************************************************
	// Calibration and source switch sequencer
	// ****************************************************************
	logic [19:0] cal_cnt_q;
	logic [19:0] abort_cnt_q;
	logic pm_enter_q;
	logic cal_step;
	logic cal_last;
	logic abort_end;

	assign cal_step = xosc_stb_s && (st_q == ST_INIT_CAL ||
		(st_q == ST_CONT_CAL && lp_rc_en_q && light_s)); // [RULE5] [RULE7]
	assign cal_last = cal_cnt_q == CAL_CYCLES - 20'h00001;
	assign abort_end = st_q == ST_ABORT &&
		abort_cnt_q == ABORT_CYCLES - 20'h00001;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_q <= ST_IDLE;
			sys_src_rc_q <= 1'b1;
			cal_cnt_q <= 20'h00000;
			abort_cnt_q <= 20'h00000;
			init_done_q <= 1'b0;
			pend_pm_q <= 1'b0;
			pm_enter_q <= 1'b0;
		end
		else
		begin
			pm_enter_q <= 1'b0;
			unique case (st_q)
				ST_IDLE:
				begin
					if (pm_req_q)
						pm_enter_q <= 1'b1;
					else if (!osc_req_q)
						st_q <= ST_WAIT_XOSC; // [RULE17]
				end
				ST_WAIT_XOSC:
				begin
					if (pm_req_q)
						pm_enter_q <= 1'b1;
					else if (osc_req_q)
						st_q <= ST_IDLE;
					else if (xosc_stb_s)
					begin
						sys_src_rc_q <= 1'b0; // [RULE15]
						init_done_q <= 1'b0; // [RULE18]
						cal_cnt_q <= 20'h00000;
						st_q <= ST_INIT_CAL; // [RULE5] [RULE17]
					end
				end
				ST_INIT_CAL:
				begin
					// Only one deep-mode request is held here. [RULE12]
					if (pm_req_q)
						pend_pm_q <= 1'b1; // [RULE10]
					if (cal_step)
						cal_cnt_q <= cal_cnt_q + 20'h00001; // [RULE8]
					if (cal_step && cal_last)
					begin
						cal_cnt_q <= 20'h00000;
						init_done_q <= 1'b1; // [RULE18]
						pend_pm_q <= 1'b0;
						if (pend_pm_q || pm_req_q)
						begin
							pm_enter_q <= 1'b1; // [RULE10]
							st_q <= ST_WAIT_XOSC;
						end
						else if (osc_req_q)
							st_q <= ST_SWITCH; // [RULE10]
						else
							st_q <= ST_CONT_CAL;
					end
				end
				ST_CONT_CAL:
				begin
					if (pm_req_q || osc_req_q)
					begin
						pend_pm_q <= pm_req_q;
						abort_cnt_q <= 20'h00000;
						st_q <= ST_ABORT; // [RULE9]
					end
					else if (cal_step)
					begin
						if (cal_last)
							cal_cnt_q <= 20'h00000; // [RULE7]
						else
							cal_cnt_q <= cal_cnt_q + 20'h00001;
					end
				end
				ST_ABORT:
				begin
					abort_cnt_q <= abort_cnt_q + 20'h00001;
					if (abort_cnt_q == ABORT_CYCLES - 20'h00001) // [RULE11]
					begin
						cal_cnt_q <= 20'h00000; // [RULE9]
						pend_pm_q <= 1'b0;
						if (pend_pm_q)
						begin
							pm_enter_q <= 1'b1;
							st_q <= ST_WAIT_XOSC;
						end
						else
							st_q <= ST_SWITCH;
					end
				end
				ST_SWITCH:
				begin
					if (rc_stb_s)
					begin
						sys_src_rc_q <= 1'b1; // [RULE15]
						st_q <= ST_IDLE;
					end
				end
				default:
				begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Calibration status outputs
	// ****************************************************************
	logic fast_rc_cal_q;
	logic [10:0] ratio_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fast_rc_cal_q <= 1'b0;
			lp_cal_busy_q <= 1'b0;
			ratio_q <= `SCC_RATIO_26M;
		end
		else
		begin
			fast_rc_cal_q <= st_q == ST_INIT_CAL; // [RULE17]
			// Busy drops with the entry pulse, so the abort ends on the same edge as the act.
			lp_cal_busy_q <= lp_rc_en_q && xosc_stb_s &&
				(st_q == ST_INIT_CAL || ((st_q == ST_CONT_CAL ||
				(st_q == ST_ABORT && !abort_end)) && light_s)); // [RULE5] [RULE9]
			ratio_q <= var_s ? `SCC_RATIO_48M : `SCC_RATIO_26M; // [RULE6]
		end
	end

	// ****************************************************************
	// Dividers
	// ****************************************************************
	logic ref_q;
	logic ref_en;
	logic [2:0] sysdiv_eff_q;
	logic [2:0] sys_code;
	logic [2:0] tick_code;

	// The 48 MHz variant references half the crystal.
	always_ff @(posedge clk)
	begin
		if (reset)
			ref_q <= 1'b0;
		else
			ref_q <= ~ref_q;
	end

	assign ref_en = var_s ? ref_q : 1'b1; // [RULE13]

	// Holding the old divider while a switch runs keeps the rate sane.
	always_ff @(posedge clk)
	begin
		if (reset)
			sysdiv_eff_q <= CTL_RST[`SCC_SYSDIV_MSB:`SCC_SYSDIV_LSB];
		else if (st_q == ST_IDLE || st_q == ST_INIT_CAL ||
			st_q == ST_CONT_CAL)
			sysdiv_eff_q <= sysdiv_q; // [RULE14]
	end

	assign sys_code = (sys_src_rc_q && sysdiv_eff_q == 3'h0) ?
		`SCC_DIV_MIN_RC : sysdiv_eff_q; // [RULE14]
	assign tick_code = (sys_src_rc_q && tick_q == 3'h0) ?
		`SCC_DIV_MIN_RC : tick_q; // [RULE13]

	scc_divider u_sys_div (
		.clk(clk),
		.reset(reset),
		.ref_en(ref_en),
		.code(sys_code),
		.tick(sys_clk_en)
	);

	scc_divider u_tick_div (
		.clk(clk),
		.reset(reset),
		.ref_en(ref_en),
		.code(tick_code),
		.tick(timer_tick)
	);

	assign wb_ack = ack_q;
	assign wb_rdata = rdata_q;
	assign lp_xtal_en = lp_xtal_en_q;
	assign lp_rc_en = lp_rc_en_q;
	assign sys_src_rc = sys_src_rc_q;
	assign fast_rc_cal = fast_rc_cal_q;
	assign lp_cal_busy = lp_cal_busy_q;
	assign lp_cal_ratio = ratio_q;
	assign deep_pm_enter = pm_enter_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_one_lp;
		!(lp_xtal_en_q && lp_rc_en_q);
	endproperty
	a_one_lp: assert property (p_one_lp) // [RULE1]
		else $error("both slow oscillators enabled");

	property p_reset_default;
		$past(reset) |-> lp_rc_en_q && slow_sel_q && !lp_xtal_en_q;
	endproperty
	a_reset_default: assert property (p_reset_default) // [RULE2]
		else $error("RC not default after reset");

	property p_sel_map;
		(lp_rc_en_q |-> $past(slow_sel_q)) and
			(lp_xtal_en_q |-> !$past(slow_sel_q));
	endproperty
	a_sel_map: assert property (p_sel_map) // [RULE3]
		else $error("slow enable disagrees with select");

	property p_sel_gate;
		$changed(slow_sel_q) |-> $past(sys_src_rc_q);
	endproperty
	a_sel_gate: assert property (p_sel_gate) // [RULE4]
		else $error("slow select changed off fast RC");

	property p_cal_cond;
		lp_cal_busy_q |-> $past(lp_rc_en_q && xosc_stb_s && !sys_src_rc_q);
	endproperty
	a_cal_cond: assert property (p_cal_cond) // [RULE5]
		else $error("calibration without its conditions");

	property p_ratio;
		##1 ratio_q == ($past(var_s) ? `SCC_RATIO_48M : `SCC_RATIO_26M);
	endproperty
	a_ratio: assert property (p_ratio) // [RULE6]
		else $error("wrong calibration ratio");

	property p_cont_restart;
		(st_q == ST_CONT_CAL && cal_step && cal_last && !osc_req_q &&
			!pm_req_q) |=> st_q == ST_CONT_CAL && cal_cnt_q == 20'h00000;
	endproperty
	a_cont_restart: assert property (p_cont_restart) // [RULE7]
		else $error("continuous calibration did not restart");

	property p_init_done;
		(st_q == ST_INIT_CAL && cal_step && cal_last) |=> init_done_q;
	endproperty
	a_init_done: assert property (p_init_done) // [RULE8] [RULE18]
		else $error("first pass end not recorded");

	property p_init_defer;
		st_q == ST_INIT_CAL |-> !sys_src_rc_q && !pm_enter_q;
	endproperty
	a_init_defer: assert property (p_init_defer) // [RULE9] [RULE10]
		else $error("action taken during first pass");

	sequence s_abort_exit;
		st_q == ST_ABORT ##1 st_q != ST_ABORT;
	endsequence
	property p_abort_len;
		s_abort_exit |-> $past(abort_cnt_q) == ABORT_CYCLES - 20'h00001;
	endproperty
	a_abort_len: assert property (p_abort_len) // [RULE11]
		else $error("abort delay wrong");

	property p_div_clamp;
		sys_src_rc_q |-> sys_code != 3'h0 && tick_code != 3'h0;
	endproperty
	a_div_clamp: assert property (p_div_clamp) // [RULE13] [RULE14]
		else $error("divide code 000 on fast RC");

	property p_div_hold;
		$changed(sysdiv_eff_q) |-> $past(st_q) inside
			{ST_IDLE, ST_INIT_CAL, ST_CONT_CAL};
	endproperty
	a_div_hold: assert property (p_div_hold) // [RULE14]
		else $error("divider changed during switch");

	property p_switch_stable;
		($rose(sys_src_rc_q) |-> $past(rc_stb_s)) and
			($fell(sys_src_rc_q) |-> $past(xosc_stb_s));
	endproperty
	a_switch_stable: assert property (p_switch_stable) // [RULE15]
		else $error("source switched before stable");

	sequence s_fast_cal;
		st_q == ST_INIT_CAL ##1 fast_rc_cal_q;
	endsequence
	property p_fast_cal;
		(st_q == ST_WAIT_XOSC && !osc_req_q && xosc_stb_s && !pm_req_q)
			|=> s_fast_cal;
	endproperty
	a_fast_cal: assert property (p_fast_cal) // [RULE17]
		else $error("fast RC calibration not started");

endmodule
`default_nettype wire

// [verif/scc_testbench.sv]
// Self-checking bench for the slow-clock and divider controller.
`timescale 1ns/10ps
`default_nettype none
module testbench
	import scc_pkg::*;
;
	localparam int CAL = 20;
	localparam int ABT = 8;
	logic clk;
	logic reset;
	logic xosc_stable;
	logic rc_stable;
	logic light_mode;
	logic variant_48m;
	scc_wb_req_s wb_req;
	logic wb_ack;
	logic [31:0] wb_rdata;
	logic lp_xtal_en;
	logic lp_rc_en;
	logic sys_src_rc;
	logic fast_rc_cal;
	logic lp_cal_busy;
	logic [10:0] lp_cal_ratio;
	logic sys_clk_en;
	logic timer_tick;
	logic deep_pm_enter;
	int miscompares;
	int num_checks;

	scc_clock_ctrl #(
		.CAL_CYCLES(20'(CAL)),
		.ABORT_CYCLES(20'(ABT))
	) u_scc_clock_ctrl (
		.clk(clk),
		.reset(reset),
		.wb_req(wb_req),
		.wb_ack(wb_ack),
		.wb_rdata(wb_rdata),
		.xosc_stable(xosc_stable),
		.rc_stable(rc_stable),
		.light_mode(light_mode),
		.variant_48m(variant_48m),
		.lp_xtal_en(lp_xtal_en),
		.lp_rc_en(lp_rc_en),
		.sys_src_rc(sys_src_rc),
		.fast_rc_cal(fast_rc_cal),
		.lp_cal_busy(lp_cal_busy),
		.lp_cal_ratio(lp_cal_ratio),
		.sys_clk_en(sys_clk_en),
		.timer_tick(timer_tick),
		.deep_pm_enter(deep_pm_enter)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************************************
	// Reporting
	// ****************************************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic check_rng(input string nm, input int lo, input int hi,
		input int got);
		num_checks++;
		if (got < lo || got > hi)
		begin
			miscompares++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask

	// ****************************************************************
	// Observation helpers, sampled on the falling edge
	// ****************************************************************
	function automatic logic pick(input int w);
		case (w)
			0: return sys_src_rc;
			1: return fast_rc_cal;
			2: return deep_pm_enter;
			3: return lp_cal_busy;
			4: return sys_clk_en;
			default: return timer_tick;
		endcase
	endfunction

	task automatic idle(input int k);
		repeat (k) @(negedge clk);
	endtask

	// Every wait is bounded so a stuck sequencer ends the run.
	task automatic wait_until(input int w, input logic v, input int lim,
		output int n);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
			if (n > lim)
			begin
				miscompares++;
				$display("[FAIL] wait %0d expected %b seen timeout", w, v);
				print_verdict();
			end
		end
		while (pick(w) !== v);
	endtask

	task automatic period(input int w, output int p);
		int n;
		wait_until(w, 1'b1, 300, n);
		wait_until(w, 1'b1, 300, p);
	endtask

	// ****************************************************************
	// Wishbone classic single cycle
	// ****************************************************************
	task automatic wb_xfer(input logic we, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		wb_req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			miscompares++;
			$display("[FAIL] bus ack expected 1 seen timeout");
			print_verdict();
		end
		q = wb_rdata;
		wb_req <= '0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb_xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		wb_xfer(1'b0, a, 8'h00, q);
	endtask

	always @(negedge clk)
		if (reset === 1'b0)
			check("both slow osc", 32'h0, 32'(lp_xtal_en & lp_rc_en));

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		int n;
		int p;
		logic [31:0] q;
		wb_req = '0;
		reset = 1'b1;
		xosc_stable = 1'b0;
		rc_stable = 1'b1;
		light_mode = 1'b1;
		variant_48m = 1'b0;
		miscompares = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		idle(3);
		check("lp_rc_en", 32'h1, 32'(lp_rc_en));
		check("sys_src_rc", 32'h1, 32'(sys_src_rc));
		check("cal ratio", 32'h2EE, 32'(lp_cal_ratio));
		rd(12'h318, q);
		check("ctrl reset", 32'hC9, q);
		wr(12'h31C, 8'hFF);
		rd(12'h31C, q);
		check("unmapped", 32'h0, q);
		rd(12'h318, q);
		check("ctrl kept", 32'hC9, q);
		// Slow source changes are legal here: the system runs on fast RC.
		wr(12'h318, 8'h49);
		idle(4);
		check("xtal on", 32'h1, 32'(lp_xtal_en));
		check("rc off", 32'h0, 32'(lp_rc_en));
		wr(12'h318, 8'hC9);
		idle(4);
		check("rc back", 32'h1, 32'(lp_rc_en));
		for (int c = 0; c < 8; c++)
		begin
			wr(12'h318, {2'b11, 3'(c), 3'(c)});
			period(4, p);
			period(4, p);
			check("sys period", (c == 0) ? 2 : 1 << c, p);
			period(5, p);
			period(5, p);
			check("tick period", (c == 0) ? 2 : 1 << c, p);
		end
		wr(12'h318, 8'h89);
		idle(10);
		check("src unstable", 32'h1, 32'(sys_src_rc));
		@(posedge clk);
		xosc_stable <= 1'b1;
		wait_until(0, 1'b0, 10, n);
		wait_until(1, 1'b1, 4, n);
		wait_until(3, 1'b1, 4, n);
		@(posedge clk);
		rc_stable <= 1'b0;
		wr(12'h318, 8'hC9);
		wait_until(1, 1'b0, CAL + 20, n);
		idle(4);
		check("rc unstable", 32'h0, 32'(sys_src_rc));
		@(posedge clk);
		rc_stable <= 1'b1;
		wait_until(0, 1'b1, 10, n);
		check("first pass over", 32'h0, 32'(fast_rc_cal));
		wr(12'h318, 8'h89);
		wait_until(0, 1'b0, 20, n);
		wait_until(1, 1'b1, 4, n);
		wait_until(1, 1'b0, CAL + 20, n);
		rd(12'h320, q);
		check("first pass flag", 32'h1, 32'(q[0]));
		repeat (3)
		begin
			idle(CAL);
			check("continuous cal", 32'h1, 32'(lp_cal_busy));
		end
		@(posedge clk);
		light_mode <= 1'b0;
		idle(4);
		check("cal paused deep", 32'h0, 32'(lp_cal_busy));
		@(posedge clk);
		light_mode <= 1'b1;
		idle(4);
		check("cal resumed", 32'h1, 32'(lp_cal_busy));
		// On the crystal a slow-select write must not move the source.
		wr(12'h318, 8'h09);
		idle(4);
		check("rc kept", 32'h1, 32'(lp_rc_en));
		rd(12'h318, q);
		check("ctrl on xosc", 32'h89, q);
		wr(12'h324, 8'h01);
		wait_until(2, 1'b1, ABT + 10, n);
		check_rng("abort delay", ABT - 1, ABT + 4, n);
		check("cal aborted", 32'h0, 32'(lp_cal_busy));
		@(posedge clk);
		variant_48m <= 1'b1;
		idle(5);
		check("cal ratio 48", 32'h5DC, 32'(lp_cal_ratio));
		period(5, p);
		period(5, p);
		check("tick period 48", 32'h4, p);
		print_verdict();
	end
endmodule
`default_nettype wire
